/* bench/cps_core_bench.sv */
// Purpose: self-checking bench for counter, flags and file logic
// Assumes: 11-bit counter, banked file, no third port
// Notes: driver queues expected outputs, a monitor compares them
`timescale 1ns/1ps
module cps_core_bench;
  import cps_pkg::*;
  typedef struct {
    logic [10:0] pc;
    logic [7:0] st;
    bit rk;
    logic [7:0] rd;
  } cps_exp_t;
  logic clk, rst_n, por, step, jl, cl, we, ol, tl, ex, sl, wc, ewe;
  logic [8:0] jt;
  logic [7:0] lit, wd, w, erd, rd, st, indirect_pointer, ta, tb, tc, ewd, stm;
  logic [4:0] ad, ea;
  logic [2:0] fm, fv;
  logic [1:0] ts;
  logic [10:0] pc, pcm;
  logic [5:0] opt;
  logic [31:0] r;
  logic [31:0] lf = 32'hBB9F3209;
  cps_exp_t q[$];
  cps_exp_t me;
  int failures, n_compared, cyc;

  cps_core #(.PC_W(11), .HAS_PORT_C(1'b0), .BANKED(1'b1)) i_cps_core (
    .clk(clk), .rst_n(rst_n), .reset_is_por(por), .step_en(step),
    .jump_load(jl), .jump_target(jt), .call_load(cl), .call_literal(lit),
    .file_we(we), .file_addr(ad), .file_wdata(wd), .flag_mask(fm),
    .flag_val(fv), .working_reg(w), .option_load(ol), .direction_registers_load(tl),
    .direction_registers_sel(ts), .evt_wdt_expire(ex), .evt_sleep(sl),
    .evt_wdt_clear(wc), .ext_rd_data(erd), .pc_out(pc),
    .status_out(st), .fsr_out(indirect_pointer), .option_out(opt), .direction_registers_a_out(ta),
    .direction_registers_b_out(tb), .direction_registers_c_out(tc), .rd_data_out(rd),
    .ext_we_out(ewe), .ext_addr_out(ea), .ext_wdata_out(ewd));
  cps_sfr_model i_cps_sfr_model (.clk(clk), .we(ewe), .addr(ea),
    .wdata(ewd), .rd_addr(ad), .rd_data(erd));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  task automatic chk(string n, logic [10:0] s, logic [10:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
    step = 1'b0;
    jl = 1'b0;
    cl = 1'b0;
    we = 1'b0;
    ol = 1'b0;
    tl = 1'b0;
    ex = 1'b0;
    sl = 1'b0;
    wc = 1'b0;
    fm = 3'h0;
  endtask

  // model of the next outputs; pages come from status before the step
  task automatic note(bit rk = 1'b0, logic [7:0] rv = 8'h00);
    cps_exp_t e;
    if (step) begin
      if (jl) pcm = {stm[6:5], jt};
      else if (cl) pcm = {stm[6:5], 1'b0, lit};
      else if (we && ad == ADDR_PCL) pcm = {stm[6:5], 1'b0, wd};
      else pcm = pcm + 11'h001;
      if (we && ad == ADDR_STATUS) stm = {wd[7:5], stm[4:3], wd[2:0]};
      for (int i = 0; i < 3; i++) if (fm[i]) stm[i] = fv[i];
    end
    if (wc) stm[4:3] = 2'h3;
    if (sl) stm[4:3] = 2'h2;
    if (ex) stm[4] = 1'b0;
    e.pc = pcm;
    e.st = stm;
    e.rk = rk;
    e.rd = rv;
    q.push_back(e);
  endtask

  always begin
    @(posedge clk);
    if (q.size() > 0) begin
      me = q.pop_front();
      #2;
      chk("pc", pc, me.pc);
      chk("status", st, me.st);
      if (me.rk) chk("rd_data", rd, me.rd);
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 1000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    por = 1'b1;
    rst_n = 1'b0;
    {step, jl, cl, we, ol, tl, ex, sl, wc} = 9'h000;
    {jt, lit, ad, wd, fm, fv, w, ts} = 46'h0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    pcm = 11'h7FF;
    stm = STATUS_POR;
    chk("pc", pc, 11'h7FF);
    chk("status", st, STATUS_POR);
    chk("fsr", indirect_pointer, FSR_ONES_BANKED);
    chk("option", opt, OPTION_RST);
    chk("direction_registers_b", tb, DIRECTION_REGISTERS_RST);
    tick();
    step = 1'b1;
    note();
    tick();
    step = 1'b1;
    jl = 1'b1;
    jt = 9'h1FF;
    note();
    tick();
    step = 1'b1;
    note();
    repeat (80) begin
      tick();
      r = rnd();
      step = r[0] | r[1];
      jt = r[16:8];
      lit = r[15:8];
      wd = r[23:16];
      fv = r[26:24];
      fm = r[29:27] & {3{r[30]}};
      ad = r[31] ? ADDR_PCL : ADDR_STATUS;
      case (r[4:2])
        3'h0: jl = 1'b1;
        3'h1: cl = 1'b1;
        3'h2: we = 1'b1;
        3'h3: we = 1'b1;
        default: ;
      endcase
      note();
    end
    tick();
    ad = ADDR_PCL;
    note(1'b1, pcm[7:0]);
    tick();
    ad = ADDR_STATUS;
    note(1'b1, stm);
    tick();
    step = 1'b1;
    we = 1'b1;
    ad = ADDR_FSR;
    wd = 8'h35;
    note();
    tick();
    step = 1'b1;
    we = 1'b1;
    ad = 5'h15;
    wd = 8'hA7;
    note();
    tick();
    ad = ADDR_INDIRECT_ACCESS_WINDOW;
    note(1'b1, 8'hA7);
    tick();
    ad = ADDR_FSR;
    note(1'b1, 8'hB5);
    tick();
    step = 1'b1;
    we = 1'b1;
    wd = 8'h00;
    note();
    tick();
    ad = ADDR_INDIRECT_ACCESS_WINDOW;
    note(1'b1, 8'h00);
    tick();
    step = 1'b1;
    we = 1'b1;
    ad = ADDR_PORT_C_PINS;
    wd = 8'h5C;
    note();
    tick();
    note(1'b1, 8'h5C);
    chk("ext_we", ewe, 1'b0);
    tick();
    step = 1'b1;
    we = 1'b1;
    ad = ADDR_PORT_B_PINS;
    r = rnd();
    wd = r[7:0];
    note();
    tick();
    chk("ext_we", ewe, 1'b1);
    chk("ext_addr", ea, ADDR_PORT_B_PINS);
    chk("ext_data", ewd, wd);
    // the far side latches the strobe one edge later, so read after it
    tick();
    note(1'b1, wd);
    tick();
    step = 1'b1;
    ol = 1'b1;
    r = rnd();
    w = r[7:0];
    note();
    tick();
    chk("option", opt, w[5:0]);
    for (int s = 0; s < 4; s++) begin
      tick();
      step = 1'b1;
      tl = 1'b1;
      ts = 2'(s);
      w = 8'h11 * 8'(s);
      note();
    end
    tick();
    chk("direction_registers_a", ta, 8'h00);
    chk("direction_registers_b", tb, 8'h11);
    chk("direction_registers_c", tc, 8'h22);
    sl = 1'b1;
    note();
    tick();
    ex = 1'b1;
    note();
    tick();
    // warm reset keeps flags, clears pages
    por = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    pcm = 11'h7FF;
    stm[7:5] = 3'h0;
    chk("pc", pc, 11'h7FF);
    chk("status", st, stm);
    tick();
    step = 1'b1;
    wc = 1'b1;
    note();
    repeat (3) tick();
    close_out();
  end
endmodule // cps_core_bench

/* bench/cps_sfr_model.sv */
// Purpose: stand-in for the timer and port registers beyond the core
// Assumes: at most one write strobe per clock from the core
// Notes: unowned addresses answer inverted data, so a misroute shows
`timescale 1ns/1ps
module cps_sfr_model (
  input wire logic clk,
  input wire logic we,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [8];
  logic own;
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr[2:0]] <= wdata;
    end
  end
  // no third port: only timer and ports a, b answer truthfully
  assign own = rd_addr == 5'h01 || rd_addr == 5'h05 || rd_addr == 5'h06;
  assign rd_data = own ? mem[rd_addr[2:0]] : ~mem[rd_addr[2:0]];
endmodule // cps_sfr_model

/* design/cps_core.sv */
// Purpose: program counter, flags, pointer, option and direction logic
// Assumes: decoder gives one step_en per instruction cycle
// Notes: file reads come back one clock after the address is given
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - counter is 9, 10 or 11 bits wide by program memory size
// RL2 - addresses beyond present memory wrap, upper bits dropped
// RL3 - any reset sets every counter bit to one
// RL4 - plain step from the reset vector wraps to address zero
// RL5 - flag-updating writes to status keep flag results, not data
// RL6 - software cannot write the watchdog-expired or sleep-entered flags
// RL7 - status bits 5 and 6 feed counter bits 9 and 10 on loads
// RL8 - every reset clears the page-select bits
// RL9 - counter adds one each cycle unless loaded
// RL10 - jump loads counter bits 8 to 0 from target field
// RL11 - low counter byte is file address 02h, read and write
// RL12 - call or low-byte write loads bits 7 to 0, clears bit 8
// RL13 - carrying across a page leaves page-select bits unchanged
// RL14 - counter bits above 7 have no file address
// RL15 - six-bit prescaler configuration is write-only
// RL16 - configuration-load instruction copies working register into it
// RL17 - every reset sets all six configuration bits
// RL18 - pointer upper bits read one: three unbanked, bit 7 banked
// RL19 - without third port, address 07h is plain data storage
// RL20 - base file splits into 7/25 or 8/24 by third port
// RL21 - banked variants add up to 48 extra data registers
// RL22 - every location reachable directly or through the pointer
// RL23 - unused page-select bits store values but never steer counter
module cps_core #(
  parameter int PC_W = 11,
  parameter bit HAS_PORT_C = 1'b0,
  parameter bit BANKED = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_is_por,
  input wire logic step_en,
  input wire logic jump_load,
  input wire logic [8:0] jump_target,
  input wire logic call_load,
  input wire logic [7:0] call_literal,
  input wire logic file_we,
  input wire logic [4:0] file_addr,
  input wire logic [7:0] file_wdata,
  input wire logic [2:0] flag_mask,
  input wire logic [2:0] flag_val,
  input wire logic [7:0] working_reg,
  input wire logic option_load,
  input wire logic direction_registers_load,
  input wire logic [1:0] direction_registers_sel,
  input wire logic evt_wdt_expire,
  input wire logic evt_sleep,
  input wire logic evt_wdt_clear,
  input wire logic [7:0] ext_rd_data,
  output logic [cps_pkg::PC_MAX_W-1:0] pc_out,
  output logic [7:0] status_out,
  output logic [7:0] fsr_out,
  output logic [5:0] option_out,
  output logic [7:0] direction_registers_a_out,
  output logic [7:0] direction_registers_b_out,
  output logic [7:0] direction_registers_c_out,
  output logic [7:0] rd_data_out,
  output logic ext_we_out,
  output logic [4:0] ext_addr_out,
  output logic [7:0] ext_wdata_out
);
  import cps_pkg::*;

  typedef struct packed {
    logic [PC_MAX_W-1:0] pc;
    logic [7:0] status;
    logic [7:0] indirect_pointer;
    logic [5:0] option;
    logic [7:0] direction_registers_a;
    logic [7:0] direction_registers_b;
    logic [7:0] direction_registers_c;
    logic [7:0] rd_data;
    logic ext_we;
    logic [4:0] ext_addr;
    logic [7:0] ext_wdata;
  } cps_state_t;

  // RL1 counter width
  localparam logic [PC_MAX_W-1:0] PC_MASK =
    PC_MAX_W'((32'd1 << PC_W) - 32'd1);
  localparam logic [7:0] FSR_ONES = BANKED ? FSR_ONES_BANKED
                                           : FSR_ONES_PLAIN;

  cps_state_t state_reg;
  cps_state_t state_next;
  logic [6:0] wr_eff;
  logic [6:0] rd_eff;
  logic wr_hit;
  logic pcl_wr;
  logic status_wr;
  logic gpr_we;
  logic [7:0] gpr_rd;
  logic [PC_MAX_W-1:0] page_bits;
  logic [7:0] st_hw;

  // RL22 direct or pointer address
  function automatic logic [6:0] eff_addr(input logic [4:0] a,
                                          input logic [7:0] f);
    logic [4:0] low;
    low = (a == ADDR_INDIRECT_ACCESS_WINDOW) ? f[4:0] : a;
    eff_addr = {(BANKED ? f[6:5] : 2'b00), low};
  endfunction

  // RL19 port C only when fitted
  function automatic logic is_ext(input logic [4:0] a);
    is_ext = (a == ADDR_TIMER) || (a == ADDR_PORT_A_PINS) ||
             (a == ADDR_PORT_B_PINS) || (HAS_PORT_C && (a == ADDR_PORT_C_PINS));
  endfunction

  // RL20 storage above the special slots
  function automatic logic is_gpr(input logic [4:0] a);
    is_gpr = (a > ADDR_PORT_C_PINS) || ((a == ADDR_PORT_C_PINS) && !HAS_PORT_C);
  endfunction

  always_comb begin
    state_next = state_reg;
    state_next.ext_we = 1'b0;
    wr_eff = eff_addr(file_addr, state_reg.indirect_pointer);
    rd_eff = eff_addr(file_addr, state_reg.indirect_pointer);
    // writing the window through a zero pointer does nothing
    wr_hit = step_en && file_we && (wr_eff[4:0] != ADDR_INDIRECT_ACCESS_WINDOW);
    pcl_wr = wr_hit && (wr_eff[4:0] == ADDR_PCL);
    status_wr = wr_hit && (wr_eff[4:0] == ADDR_STATUS);
    gpr_we = wr_hit && is_gpr(wr_eff[4:0]);
    // RL7 RL23 page field, masked to width
    page_bits = {state_reg.status[ST_PA1], state_reg.status[ST_PA0],
                 9'h000} & PC_MASK;

    // hardware events on the reset-status flags
    st_hw = state_reg.status;
    if (evt_wdt_clear) begin
      st_hw[ST_TO] = 1'b1;
      st_hw[ST_PD] = 1'b1;
    end
    if (evt_sleep) begin
      st_hw[ST_TO] = 1'b1;
      st_hw[ST_PD] = 1'b0;
    end
    if (evt_wdt_expire) begin
      st_hw[ST_TO] = 1'b0;
    end

    state_next.status = st_hw;
    // RL6 data never reaches bits 4 and 3
    if (status_wr) begin
      state_next.status[7:5] = file_wdata[7:5];
      state_next.status[2:0] = file_wdata[2:0];
    end
    // RL5 flag results win over data
    for (int i = 0; i < 3; i++) begin
      if (step_en && flag_mask[i]) begin
        state_next.status[i] = flag_val[i];
      end
    end

    if (step_en) begin
      if (jump_load) begin
        // RL10 target field into bits 8:0
        state_next.pc = (page_bits | {2'b00, jump_target}) & PC_MASK;
      end else if (call_load) begin
        // RL12 bit 8 forced low
        state_next.pc = (page_bits | {3'b000, call_literal}) & PC_MASK;
      end else if (pcl_wr) begin
        // RL11 RL12 low byte write is a computed jump
        state_next.pc = (page_bits | {3'b000, file_wdata}) & PC_MASK;
      end else begin
        // RL9 RL2 RL4 RL13 step with wrap; page bits untouched
        state_next.pc = (state_reg.pc + 11'h001) & PC_MASK;
      end
    end

    if (wr_hit && (wr_eff[4:0] == ADDR_FSR)) begin
      state_next.indirect_pointer = file_wdata | FSR_ONES;
    end
    if (wr_hit && is_ext(wr_eff[4:0])) begin
      state_next.ext_we = 1'b1;
      state_next.ext_addr = wr_eff[4:0];
      state_next.ext_wdata = file_wdata;
    end

    // RL16 RL15 configuration loads, no read path
    if (step_en && option_load) begin
      state_next.option = working_reg[5:0];
    end
    if (step_en && direction_registers_load) begin
      case (direction_registers_sel)
        DIRECTION_REGISTERS_SEL_A: state_next.direction_registers_a = working_reg;
        DIRECTION_REGISTERS_SEL_B: state_next.direction_registers_b = working_reg;
        DIRECTION_REGISTERS_SEL_C: state_next.direction_registers_c = working_reg;
        default: state_next.direction_registers_a = state_reg.direction_registers_a;
      endcase
    end

    // RL14 only the low byte has an address
    if (is_ext(rd_eff[4:0])) begin
      state_next.rd_data = ext_rd_data;
    end else if (is_gpr(rd_eff[4:0])) begin
      state_next.rd_data = gpr_rd;
    end else begin
      case (rd_eff[4:0])
        ADDR_PCL: state_next.rd_data = state_reg.pc[7:0];
        ADDR_STATUS: state_next.rd_data = state_reg.status;
        // RL18 unused pointer bits read one
        ADDR_FSR: state_next.rd_data = state_reg.indirect_pointer | FSR_ONES;
        default: state_next.rd_data = 8'h00;
      endcase
    end

    if (!rst_n) begin
      // RL3 RL8 RL17 reset values
      state_next.pc = PC_MASK;
      state_next.status[7:5] = 3'b000;
      if (reset_is_por) begin
        state_next.status[4:0] = STATUS_POR[4:0];
      end else begin
        state_next.status[4:0] = st_hw[4:0];
      end
      state_next.indirect_pointer = FSR_ONES;
      state_next.option = OPTION_RST;
      state_next.direction_registers_a = DIRECTION_REGISTERS_RST;
      state_next.direction_registers_b = DIRECTION_REGISTERS_RST;
      state_next.direction_registers_c = DIRECTION_REGISTERS_RST;
      state_next.rd_data = 8'h00;
      state_next.ext_we = 1'b0;
      state_next.ext_addr = 5'h00;
      state_next.ext_wdata = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  // RL21 banked data storage
  cps_gpr_file #(
    .DEPTH(GPR_DEPTH)
  ) u_gpr (
    .clk(clk),
    .we(gpr_we && rst_n),
    .wr_addr(wr_eff),
    .wr_data(file_wdata),
    .rd_addr(rd_eff),
    .rd_data(gpr_rd)
  );

  assign pc_out = state_reg.pc;
  assign status_out = state_reg.status;
  // ones are stored with every write and reset, so no gate is needed here
  assign fsr_out = state_reg.indirect_pointer;
  assign option_out = state_reg.option;
  assign direction_registers_a_out = state_reg.direction_registers_a;
  assign direction_registers_b_out = state_reg.direction_registers_b;
  assign direction_registers_c_out = state_reg.direction_registers_c;
  assign rd_data_out = state_reg.rd_data;
  assign ext_we_out = state_reg.ext_we;
  assign ext_addr_out = state_reg.ext_addr;
  assign ext_wdata_out = state_reg.ext_wdata;

  sequence seq_plain_step;
    rst_n && step_en && !jump_load && !call_load && !pcl_wr;
  endsequence

  sequence seq_no_status_touch;
    !status_wr && (flag_mask == 3'b000);
  endsequence

  a_reset_vector: assert property (@(posedge clk) // RL3
    !rst_n |=> pc_out == PC_MASK)
    else $error("counter not all ones after reset");

  a_page_reset: assert property (@(posedge clk) // RL8
    !rst_n |=> status_out[7:5] == 3'b000)
    else $error("page bits not cleared by reset");

  a_option_reset: assert property (@(posedge clk) // RL17
    !rst_n |=> option_out == OPTION_RST)
    else $error("configuration not all ones after reset");

  a_pc_increment: assert property (@(posedge clk) disable iff (!rst_n)
    seq_plain_step |=> pc_out == // RL9
      ((($past(pc_out) + 11'h001)) & PC_MASK))
    else $error("counter did not step by one");

  a_vector_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (pc_out == PC_MASK) ##0 seq_plain_step |=> // RL4
      pc_out == 11'h000)
    else $error("reset vector step did not wrap to zero");

  a_jump_target: assert property (@(posedge clk) disable iff (!rst_n)
    step_en && jump_load |=> pc_out[8:0] == $past(jump_target) && // RL10
      pc_out[10:9] == ($past(status_out[6:5]) & PC_MASK[10:9]))
    else $error("jump target or page not loaded");

  a_call_bit8: assert property (@(posedge clk) disable iff (!rst_n)
    step_en && !jump_load && (call_load || pcl_wr) |=> // RL12
      !pc_out[8])
    else $error("bit 8 not cleared on call or low-byte write");

  a_sleep_flags: assert property (@(posedge clk) disable iff (!rst_n)
    status_wr && !evt_wdt_expire && !evt_sleep && !evt_wdt_clear |=>
      $stable(status_out[4:3])) // RL6
    else $error("software changed reset-status flags");

  a_flag_block: assert property (@(posedge clk) disable iff (!rst_n)
    status_wr && (flag_mask == 3'b111) |=> // RL5
      status_out[2:0] == $past(flag_val))
    else $error("data write reached flag bits");

  a_page_keep: assert property (@(posedge clk) disable iff (!rst_n)
    seq_plain_step ##0 seq_no_status_touch |=> // RL13
      $stable(status_out[7:5]))
    else $error("page bits changed on plain step");

  a_option_load: assert property (@(posedge clk) disable iff (!rst_n)
    step_en && option_load |=> option_out == $past(working_reg[5:0]))
    else $error("configuration load failed"); // RL16

endmodule // cps_core

/* design/cps_gpr_file.sv */
// Purpose: general-purpose data storage, base and banked locations
// Assumes: caller resolves the 7-bit file address
// Notes: read is combinational, write on clock edge
`timescale 1ns/1ps
module cps_gpr_file #(
  parameter int DEPTH = cps_pkg::GPR_DEPTH
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data
);
  import cps_pkg::*;

  logic [7:0] mem [DEPTH];

  // low 16 locations are common; upper 16 repeat per bank
  function automatic logic [6:0] phys(input logic [6:0] a);
    if (a[4]) begin
      phys = {1'b0, a[6:5], a[3:0]} + GPR_BANK_BASE;
    end else begin
      phys = {3'b000, a[3:0]};
    end
  endfunction

  // contents carry no reset, as ordinary data memory
  always_ff @(posedge clk) begin
    if (we) begin
      mem[phys(wr_addr)] <= wr_data;
    end
  end

  assign rd_data = mem[phys(rd_addr)];
endmodule // cps_gpr_file

/* design/cps_pkg.sv */
// Purpose: shared constants for the core counter, flags and file logic
// Assumes: one step_en pulse per instruction cycle
// Notes: widths sized to the largest variant; smaller ones mask bits
package cps_pkg;
  localparam int PC_MAX_W = 11;
  localparam int GPR_DEPTH = 80;
  // file addresses
  localparam logic [4:0] ADDR_INDIRECT_ACCESS_WINDOW = 5'h00;
  localparam logic [4:0] ADDR_TIMER = 5'h01;
  localparam logic [4:0] ADDR_PCL = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_FSR = 5'h04;
  localparam logic [4:0] ADDR_PORT_A_PINS = 5'h05;
  localparam logic [4:0] ADDR_PORT_B_PINS = 5'h06;
  localparam logic [4:0] ADDR_PORT_C_PINS = 5'h07;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_PA0 = 5;
  localparam int ST_PA1 = 6;
  localparam int ST_PA2 = 7;
  // values after reset
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [5:0] OPTION_RST = 6'h3F;
  localparam logic [7:0] DIRECTION_REGISTERS_RST = 8'hFF;
  localparam logic [7:0] FSR_ONES_PLAIN = 8'hE0;
  localparam logic [7:0] FSR_ONES_BANKED = 8'h80;
  // direction register select codes
  localparam logic [1:0] DIRECTION_REGISTERS_SEL_A = 2'h0;
  localparam logic [1:0] DIRECTION_REGISTERS_SEL_B = 2'h1;
  localparam logic [1:0] DIRECTION_REGISTERS_SEL_C = 2'h2;
  localparam logic [6:0] GPR_BANK_BASE = 7'h10;
endpackage
